// ---- src/smabp_sfr_map.sv ----
// Register area select and bit protection front end for the CPU's
// direct accesses at 0x80 and above.
// Assumes one-cycle read and write strobes from the core, synchronous to
// clk_in, and register areas that act on the registered fwd_* outputs.
`timescale 1ns/1ps

module smabp_sfr_map (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] addr_in,
    input  wire logic       rd_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic [7:0] prot_mask_in,
    output logic      [7:0] rd_data_out,
    output logic            rd_hit_out,
    output logic      [7:0] fwd_addr_out,
    output logic      [7:0] fwd_wdata_out,
    output logic      [7:0] fwd_wmask_out,
    output logic            fwd_std_wr_out,
    output logic            fwd_std_rd_out,
    output logic            fwd_map_wr_out,
    output logic            fwd_map_rd_out,
    output logic            register_map_select_out,
    output logic      [1:0] prot_mode_out,
    output logic            prot_status_out
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic       in_sfr;
    logic       hit_sysctl;
    logic       hit_key;
    logic       own_hit;
    logic       fwd_go;
    logic       key_wr;
    logic [6:0] sysctl_spare;
    logic [7:0] sysctl_value;
    logic [7:0] key_value;
    logic [7:0] next_rd_data;
    logic [7:0] next_wmask;

    // Addresses below the base belong to plain data memory
    assign in_sfr     = (addr_in >= smabp_pkg::SFR_BASE);
    // Control register answers in both areas so software can always switch back
    assign hit_sysctl = in_sfr && (addr_in == smabp_pkg::SYSCTL_ADDR);
    assign hit_key    = in_sfr && (addr_in == smabp_pkg::KEY_ADDR) && !register_map_select_out;
    assign own_hit    = hit_sysctl || hit_key;
    assign fwd_go     = in_sfr && !own_hit;
    assign key_wr     = wr_in && hit_key;

    // ****************************************************************
    // Read values
    // ****************************************************************
    // Password field is write-only and reads as zero
    assign sysctl_value = {sysctl_spare, register_map_select_out};
    assign key_value    = {5'h00, prot_status_out, prot_mode_out};
    assign next_rd_data = hit_sysctl ? sysctl_value : (hit_key ? key_value : 8'h00);
    // Closed lock strips the protected lanes; no error is flagged
    assign next_wmask   = prot_status_out ? ~prot_mask_in : 8'hff;

    // ****************************************************************
    // Key unit
    // ****************************************************************
    smabp_key_unit i_smabp_key_unit (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .wr_in      (key_wr),
        .wdata_in   (wdata_in),
        .mode_out   (prot_mode_out),
        .status_out (prot_status_out)
    );

    // ****************************************************************
    // System control register
    // ****************************************************************
    // Map select only moves on a software write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            register_map_select_out <= smabp_pkg::SYSCTL_RESET[smabp_pkg::MAP_SEL_BIT];
            sysctl_spare            <= smabp_pkg::SYSCTL_RESET[7:1];
        end else if (wr_in && hit_sysctl) begin
            register_map_select_out <= wdata_in[smabp_pkg::MAP_SEL_BIT];
            sysctl_spare            <= wdata_in[7:1];
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // One cycle read latency for the block's own registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
            rd_hit_out  <= 1'b0;
        end else begin
            rd_data_out <= rd_in ? next_rd_data : 8'h00;
            rd_hit_out  <= rd_in && own_hit;
        end
    end

    // ****************************************************************
    // Area forwarding
    // ****************************************************************
    // Area chosen by the select value in force when the access arrives;
    // a write to 0x8f steers only the accesses after it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fwd_addr_out   <= 8'h00;
            fwd_wdata_out  <= 8'h00;
            fwd_wmask_out  <= 8'h00;
            fwd_std_wr_out <= 1'b0;
            fwd_std_rd_out <= 1'b0;
            fwd_map_wr_out <= 1'b0;
            fwd_map_rd_out <= 1'b0;
        end else begin
            fwd_addr_out   <= addr_in;
            fwd_wdata_out  <= wdata_in;
            fwd_wmask_out  <= next_wmask;
            fwd_std_wr_out <= wr_in && fwd_go && !register_map_select_out;
            fwd_std_rd_out <= rd_in && fwd_go && !register_map_select_out;
            fwd_map_wr_out <= wr_in && fwd_go && register_map_select_out;
            fwd_map_rd_out <= rd_in && fwd_go && register_map_select_out;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    smabp_pkg::smabp_cmd_e key_cmd;
    logic                  first_after_rst;

    assign key_cmd = key_wr ? smabp_pkg::decode_pass(wdata_in) : smabp_pkg::CMD_NONE;

    // Marks the first cycle after reset release
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            first_after_rst <= 1'b1;
        end else begin
            first_after_rst <= 1'b0;
        end
    end

    AST_BELOW_BASE: assert property (
        ((rd_in || wr_in) && addr_in < smabp_pkg::SFR_BASE) |=>
            !(fwd_std_wr_out || fwd_std_rd_out || fwd_map_wr_out || fwd_map_rd_out
              || rd_hit_out))
        else $error("Access below base reached a register area");

    AST_SAME_RANGE: assert property (
        (fwd_std_rd_out || fwd_map_rd_out || fwd_std_wr_out || fwd_map_wr_out) |->
            (fwd_addr_out == $past(addr_in)) && (fwd_addr_out >= smabp_pkg::SFR_BASE))
        else $error("Forwarded address differs from the CPU address");

    AST_MAP_STEER: assert property (
        (wr_in && fwd_go && register_map_select_out) |=> fwd_map_wr_out && !fwd_std_wr_out)
        else $error("Mapped write not steered to the mapped area");

    AST_STD_STEER: assert property (
        (rd_in && fwd_go && !register_map_select_out) |=> fwd_std_rd_out && !fwd_map_rd_out)
        else $error("Standard read not steered to the standard area");

    AST_MAP_HOLD: assert property (
        !(wr_in && hit_sysctl) |=> $stable(register_map_select_out))
        else $error("Map select changed without a software write");

    AST_MODE_OFF_OPEN: assert property (
        (prot_mode_out == smabp_pkg::MODE_OFF) |-> !prot_status_out)
        else $error("Protection closed while the scheme is off");

    AST_MODE_LOAD: assert property (
        (key_cmd == smabp_pkg::CMD_MODE) |=>
            prot_mode_out == $past(wdata_in[smabp_pkg::MODE_MSB:smabp_pkg::MODE_LSB]))
        else $error("Mode pattern did not load the mode field");

    AST_MODE_DIRECT: assert property (
        (key_cmd != smabp_pkg::CMD_MODE) |=> $stable(prot_mode_out))
        else $error("Mode changed without the mode pattern");

    AST_OPEN: assert property (
        (key_cmd == smabp_pkg::CMD_OPEN) |=> !prot_status_out)
        else $error("Open pattern left protection closed");

    AST_CLOSE: assert property (
        (key_cmd == smabp_pkg::CMD_CLOSE && prot_mode_out != smabp_pkg::MODE_OFF) |=>
            prot_status_out)
        else $error("Close pattern left protection open");

    AST_OTHER_IGNORED: assert property (
        (key_wr && key_cmd == smabp_pkg::CMD_NONE) |=>
            $stable(prot_status_out) && $stable(prot_mode_out))
        else $error("Unknown pattern altered protection state");

    AST_STATUS_READ: assert property (
        (rd_in && hit_key) |=> rd_hit_out && (rd_data_out[7:3] == 5'h00)
            && (rd_data_out[smabp_pkg::STATUS_BIT] == $past(prot_status_out)))
        else $error("Key read does not show the protection status");

    AST_RESET_STATE: assert property (
        first_after_rst |-> ({5'h00, prot_status_out, prot_mode_out} == smabp_pkg::KEY_RESET))
        else $error("Key register not at its reset value");

    AST_DISCARD: assert property (
        (wr_in && fwd_go && prot_status_out) |=>
            ((fwd_wmask_out & $past(prot_mask_in)) == 8'h00))
        else $error("Protected lanes enabled while closed");

    COV_MAPPED_WRITE: cover property (fwd_map_wr_out);
    COV_OPEN_THEN_CLOSE: cover property (
        key_cmd == smabp_pkg::CMD_OPEN ##[1:20] key_cmd == smabp_pkg::CMD_CLOSE);
    COV_MODE_OFF: cover property (
        key_cmd == smabp_pkg::CMD_MODE ##1 prot_mode_out == smabp_pkg::MODE_OFF);
    COV_MAP_TOGGLE: cover property ($rose(register_map_select_out) ##[1:20]
        $fell(register_map_select_out));

endmodule

// ---- common/smabp_pkg.sv ----
// Constants, command type and pattern decoder for the register map
// select and bit protection block.
// Assumes an 8-bit direct address and an 8-bit data path from the CPU core.

package smabp_pkg;

    // ****************************************************************
    // Addresses
    // ****************************************************************
    localparam logic [7:0] SFR_BASE     = 8'h80;  // Lowest direct address of the register area
    localparam logic [7:0] SYSCTL_ADDR  = 8'h8f;  // System control, seen in both areas
    localparam logic [7:0] KEY_ADDR     = 8'hbb;  // Protection key, standard area only

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int         MAP_SEL_BIT  = 0;
    localparam int         MODE_LSB     = 0;
    localparam int         MODE_MSB     = 1;
    localparam int         STATUS_BIT   = 2;
    localparam int         PASS_LSB     = 3;
    localparam int         PASS_MSB     = 7;
    localparam logic [7:0] SYSCTL_RESET = 8'h00;
    localparam logic [7:0] KEY_RESET    = 8'h07;
    localparam logic [1:0] MODE_RESET   = 2'h3;
    localparam logic [1:0] MODE_OFF     = 2'h0;
    localparam logic       LOCK_RESET   = 1'b1;

    // ****************************************************************
    // Password patterns
    // ****************************************************************
    localparam logic [4:0] PASS_MODE    = 5'h18;  // Loads the scheme mode
    localparam logic [4:0] PASS_OPEN    = 5'h13;  // Opens protected bits
    localparam logic [4:0] PASS_CLOSE   = 5'h15;  // Closes protected bits

    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_MODE,
        CMD_OPEN,
        CMD_CLOSE
    } smabp_cmd_e;

    // Classify a byte written to the key register
    function automatic smabp_cmd_e decode_pass(input logic [7:0] data);
        logic [4:0] pass;
        pass = data[PASS_MSB:PASS_LSB];
        if (pass == PASS_MODE) begin
            return CMD_MODE;
        end else if (pass == PASS_OPEN) begin
            return CMD_OPEN;
        end else if (pass == PASS_CLOSE) begin
            return CMD_CLOSE;
        end
        return CMD_NONE;
    endfunction

endpackage

// ---- src/smabp_key_unit.sv ----
// Password state of the bit protection scheme: mode field and lock.
// Assumes the caller asserts wr_in only for a write to the key register.
`timescale 1ns/1ps

module smabp_key_unit (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [1:0] mode_out,
    output logic            status_out
);

    // ****************************************************************
    // Pattern decode
    // ****************************************************************
    smabp_pkg::smabp_cmd_e cmd;
    logic                  locked;
    logic            [1:0] next_mode;
    logic                  next_locked;
    logic                  scheme_on;

    // Only the three patterns act; all else is dropped
    assign cmd         = wr_in ? smabp_pkg::decode_pass(wdata_in) : smabp_pkg::CMD_NONE;
    assign scheme_on   = (mode_out != smabp_pkg::MODE_OFF);
    // Mode bits only move alongside the mode pattern
    assign next_mode   = (cmd == smabp_pkg::CMD_MODE) ?
                         wdata_in[smabp_pkg::MODE_MSB:smabp_pkg::MODE_LSB] : mode_out;
    assign next_locked = (cmd == smabp_pkg::CMD_OPEN) ? 1'b0 :
                         ((cmd == smabp_pkg::CMD_CLOSE) && scheme_on) ? 1'b1 :
                         locked;

    // ****************************************************************
    // State
    // ****************************************************************
    // Status is stored, not derived, so the output is a plain flop
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_out   <= smabp_pkg::MODE_RESET;
            locked     <= smabp_pkg::LOCK_RESET;
            status_out <= smabp_pkg::LOCK_RESET;
        end else begin
            mode_out   <= next_mode;
            locked     <= next_locked;
            status_out <= next_locked && (next_mode != smabp_pkg::MODE_OFF);
        end
    end

endmodule

// ---- dv/smabp_sfr_map_tb_top.sv ----
// Self-checking bench for the register map select and bit protection block.
// Assumes the core strobes last one cycle and own reads answer one cycle later.
`timescale 1ns/1ps

module smabp_sfr_map_tb_top;

    // ****************************************************************
    // Stimulus, observation and bookkeeping
    // ****************************************************************
    logic       clk_in       = 1'b0;
    logic       rst_in       = 1'b1;
    logic [7:0] addr_in      = 8'h00;
    logic       rd_in        = 1'b0;
    logic       wr_in        = 1'b0;
    logic [7:0] wdata_in     = 8'h00;
    logic [7:0] prot_mask_in = 8'h00;
    logic [7:0] rd_data_out;
    logic       rd_hit_out;
    logic [7:0] fwd_addr_out;
    logic [7:0] fwd_wdata_out;
    logic [7:0] fwd_wmask_out;
    logic       fwd_std_wr_out;
    logic       fwd_std_rd_out;
    logic       fwd_map_wr_out;
    logic       fwd_map_rd_out;
    logic       register_map_select_out;
    logic [1:0] prot_mode_out;
    logic       prot_status_out;
    logic [7:0] c_rd;
    logic [7:0] c_fm;
    logic [7:0] c_fa;
    logic [4:0] c_st;
    logic [7:0] c_fd;
    int         n_errors     = 0;
    int         comparisons  = 0;
    localparam logic [7:0] KEY = smabp_pkg::KEY_ADDR;

    smabp_sfr_map i_smabp_sfr_map (
        .clk_in                  (clk_in),
        .rst_in                  (rst_in),
        .addr_in                 (addr_in),
        .rd_in                   (rd_in),
        .wr_in                   (wr_in),
        .wdata_in                (wdata_in),
        .prot_mask_in            (prot_mask_in),
        .rd_data_out             (rd_data_out),
        .rd_hit_out              (rd_hit_out),
        .fwd_addr_out            (fwd_addr_out),
        .fwd_wdata_out           (fwd_wdata_out),
        .fwd_wmask_out           (fwd_wmask_out),
        .fwd_std_wr_out          (fwd_std_wr_out),
        .fwd_std_rd_out          (fwd_std_rd_out),
        .fwd_map_wr_out          (fwd_map_wr_out),
        .fwd_map_rd_out          (fwd_map_rd_out),
        .register_map_select_out (register_map_select_out),
        .prot_mode_out           (prot_mode_out),
        .prot_status_out         (prot_status_out)
    );

    // 20 MHz clock
    initial begin
        forever #25 clk_in = ~clk_in;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // One strobed access; pulses are caught at the next falling edge,
    // mid-way through the only cycle in which they stand
    task automatic acc(input logic r, input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [7:0] m);
        @(negedge clk_in);
        rd_in        = r;
        wr_in        = w;
        addr_in      = a;
        wdata_in     = d;
        prot_mask_in = m;
        @(negedge clk_in);
        c_rd  = rd_data_out;
        c_fm  = fwd_wmask_out;
        c_fa  = fwd_addr_out;
        c_fd  = fwd_wdata_out;
        c_st  = {rd_hit_out, fwd_std_wr_out, fwd_std_rd_out, fwd_map_wr_out, fwd_map_rd_out};
        rd_in = 1'b0;
        wr_in = 1'b0;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Key state as {status, mode}
    function automatic logic [7:0] kst();
        return {5'h00, prot_status_out, prot_mode_out};
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk(kst(), 8'h07, "reset status and mode");
        acc(1'b1, 1'b0, KEY, 8'h00, 8'h00);
        chk(c_rd, 8'h07, "key reset read");
        chk({3'h0, c_st}, 8'h10, "key read hit");
    endtask

    task automatic t_protect();
        acc(1'b0, 1'b1, 8'hc0, 8'h55, 8'h0f);
        chk(c_fm, 8'hf0, "closed lanes dropped");
        chk({3'h0, c_st}, 8'h08, "std write forwarded");
        chk(c_fa, 8'hc0, "forwarded address");
        chk(c_fd, 8'h55, "forwarded write data");
        acc(1'b0, 1'b1, KEY, 8'h98, 8'h00);
        chk(kst(), 8'h03, "open pattern");
        acc(1'b1, 1'b0, KEY, 8'h00, 8'h00);
        chk(c_rd, 8'h03, "key read when open");
        acc(1'b0, 1'b1, 8'hc0, 8'h55, 8'h0f);
        chk(c_fm, 8'hff, "open lanes kept");
    endtask

    task automatic t_patterns();
        logic [7:0] bad [4] = '{8'h00, 8'hb0, 8'ha0, 8'hff};
        foreach (bad[i]) begin
            acc(1'b0, 1'b1, KEY, bad[i], 8'h00);
            chk(kst(), 8'h03, "unknown pattern ignored");
        end
        acc(1'b0, 1'b1, KEY, 8'ha8, 8'h00);
        chk(kst(), 8'h07, "close pattern");
        acc(1'b0, 1'b1, KEY, 8'h10, 8'h00);
        chk(kst(), 8'h07, "unknown pattern when closed");
    endtask

    // Open, then close with the scheme off: the close must not stick
    task automatic t_mode();
        acc(1'b0, 1'b1, KEY, 8'hc0, 8'h00);
        chk(kst(), 8'h00, "mode 00 loaded");
        acc(1'b0, 1'b1, KEY, 8'h98, 8'h00);
        acc(1'b0, 1'b1, KEY, 8'ha8, 8'h00);
        chk(kst(), 8'h00, "close ignored when off");
        acc(1'b0, 1'b1, 8'hd0, 8'h5a, 8'hff);
        chk(c_fm, 8'hff, "scheme off writes all");
        acc(1'b0, 1'b1, KEY, 8'hc1, 8'h00);
        chk(kst(), 8'h01, "mode 01 keeps lock open");
        acc(1'b0, 1'b1, KEY, 8'ha8, 8'h00);
        chk(kst(), 8'h05, "mode 01 enables scheme");
        acc(1'b0, 1'b1, KEY, 8'hc3, 8'h00);
        chk(kst(), 8'h07, "mode 11 loaded");
    endtask

    task automatic t_map();
        acc(1'b0, 1'b1, smabp_pkg::SYSCTL_ADDR, 8'h01, 8'h00);
        chk({7'h00, register_map_select_out}, 8'h01, "map select set");
        acc(1'b0, 1'b1, 8'hc0, 8'h11, 8'h00);
        chk({3'h0, c_st}, 8'h02, "mapped write");
        acc(1'b1, 1'b0, KEY, 8'h00, 8'h00);
        chk({3'h0, c_st}, 8'h01, "key address mapped");
        acc(1'b1, 1'b0, smabp_pkg::SYSCTL_ADDR, 8'h00, 8'h00);
        chk(c_rd, 8'h01, "map select kept");
        acc(1'b0, 1'b1, smabp_pkg::SYSCTL_ADDR, 8'h00, 8'h00);
        acc(1'b1, 1'b0, 8'hff, 8'h00, 8'h00);
        chk({c_st, c_fa[2:0]}, 8'h27, "std read at top");
        chk(c_rd, 8'h00, "forwarded read leaves own data zero");
        acc(1'b1, 1'b1, 8'h7f, 8'h00, 8'h00);
        chk({3'h0, c_st}, 8'h00, "below area ignored");
    endtask

    // ****************************************************************
    // Verdict, watchdog and main sequence
    // ****************************************************************
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Run needs well under 200 cycles; allow ten times that
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    // Reset for two cycles, release on a falling edge
    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        t_reset();
        t_protect();
        t_patterns();
        t_mode();
        t_map();
        stop_test();
    end

endmodule
